// ===== logic/dsc_map.svh
// Constants for the switch bank configuration decoder.
// Assumes inclusion by bare name from the decoder sources only.
`ifndef DSC_MAP_SVH
`define DSC_MAP_SVH

// Switch bank widths
`define DSC_RATE_W       4
`define DSC_NODE_W       8
// Rate codes
`define DSC_RATE_MAX     4'h8
`define DSC_RATE_AUTO    4'h9
// Node identity limits
`define DSC_NODE_INVALID 8'h00
`define DSC_NODE_MAX     8'h7f
// Factory settings of the switches
`define DSC_RATE_DEF     4'h1
`define DSC_NODE_DEF     8'h20
// Bit rates in kbit/s, one per code 0 to 8
`define DSC_KBPS_0       10'h00a
`define DSC_KBPS_1       10'h014
`define DSC_KBPS_2       10'h032
`define DSC_KBPS_3       10'h064
`define DSC_KBPS_4       10'h07d
`define DSC_KBPS_5       10'h0fa
`define DSC_KBPS_6       10'h1f4
`define DSC_KBPS_7       10'h320
`define DSC_KBPS_8       10'h3e8

`endif

// ===== logic/dsc_pkg.sv
// Types for the switch bank configuration decoder.
// Assumes dsc_map.svh is on the include path.
`include "dsc_map.svh"

package dsc_pkg;

  // Decoded bus configuration
  typedef struct packed {
    logic       auto_scan;  // Scan for bit rate
    logic       rate_bad;   // Rate code above the auto-scan code
    logic [9:0] kbps;       // Fixed rate, kbit/s
    logic       node_bad;   // Node code not usable
    logic [6:0] node_id;    // Node identity
  } dsc_cfg_t;

  // Loader states
  typedef enum logic [1:0] {
    DSC_ST_RESET,
    DSC_ST_SYNC,
    DSC_ST_HOLD
  } dsc_state_t;

endpackage

// ===== logic/dsc_decode.sv
// Combinational decode of the two switch bank values.
// Assumes banks are already synchronised and stable.
`timescale 1ns/1ps
`include "dsc_map.svh"

module dsc_decode
  import dsc_pkg::*;
(
  input  wire logic [`DSC_RATE_W-1:0] rate_sw_i,  // Rate bank, bit 0 = position 1
  input  wire logic [`DSC_NODE_W-1:0] node_sw_i,  // Node bank, bit 0 = position 1
  output dsc_cfg_t                    cfg_o       // Decoded configuration
);

  // Table lookup and validity checks
  always_comb
  begin
    cfg_o = '0;
    case (rate_sw_i)
      4'h0:           cfg_o.kbps = `DSC_KBPS_0;
      4'h1:           cfg_o.kbps = `DSC_KBPS_1;
      4'h2:           cfg_o.kbps = `DSC_KBPS_2;
      4'h3:           cfg_o.kbps = `DSC_KBPS_3;
      4'h4:           cfg_o.kbps = `DSC_KBPS_4;
      4'h5:           cfg_o.kbps = `DSC_KBPS_5;
      4'h6:           cfg_o.kbps = `DSC_KBPS_6;
      4'h7:           cfg_o.kbps = `DSC_KBPS_7;
      `DSC_RATE_MAX:  cfg_o.kbps = `DSC_KBPS_8;
      `DSC_RATE_AUTO: cfg_o.auto_scan = 1'b1;
      // Codes 10..15 are undefined; flag rather than guess
      default:        cfg_o.rate_bad = 1'b1;
    endcase
    // Zero is never adopted; above 127 does not fit a 7-bit identity
    cfg_o.node_bad = (node_sw_i == `DSC_NODE_INVALID) || (node_sw_i > `DSC_NODE_MAX);
    if (!cfg_o.node_bad)
    begin
      cfg_o.node_id = node_sw_i[6:0];
    end
  end

endmodule

// ===== logic/dsc_config_loader.sv
// Top of the switch bank configuration decoder.
// Assumes switch pins are asynchronous and one 125 MHz clock with sync reset.
`timescale 1ns/1ps
`include "dsc_map.svh"

module dsc_config_loader
  import dsc_pkg::*;
#(
  parameter int SYNC_WAIT = 4  // Cycles after sync before sampling
)
(
  input  wire logic                    REF_CLK_I,     // 125 MHz clock
  input  wire logic                    RST_I,         // Sync reset, active high
  input  wire logic [`DSC_RATE_W-1:0]  RATE_SW_I,     // Rate switch bank
  input  wire logic [`DSC_NODE_W-1:0]  NODE_SW_I,     // Node switch bank
  output logic                         CFG_VALID_O,   // Configuration latched
  output logic                         AUTO_SCAN_O,   // Bit rate scan requested
  output logic                         RATE_BAD_O,    // Undefined rate code
  output logic [9:0]                   RATE_KBPS_O,   // Fixed rate, kbit/s
  output logic                         NODE_BAD_O,    // Node setting invalid
  output logic [6:0]                   NODE_ID_O      // Node identity
);

  localparam logic [2:0] WAIT_LAST = 3'(SYNC_WAIT - 1);

  // Two-stage synchronisers for both banks
  logic [`DSC_RATE_W-1:0] rate_s1_r;   // First stage, read only by second
  logic [`DSC_RATE_W-1:0] rate_s2_r;   // Safe to decode
  logic [`DSC_NODE_W-1:0] node_s1_r;   // First stage, read only by second
  logic [`DSC_NODE_W-1:0] node_s2_r;   // Safe to decode
  logic [`DSC_RATE_W-1:0] rate_s1_nxt;
  logic [`DSC_RATE_W-1:0] rate_s2_nxt;
  logic [`DSC_NODE_W-1:0] node_s1_nxt;
  logic [`DSC_NODE_W-1:0] node_s2_nxt;

  // Loader state and held configuration
  dsc_state_t state_r;     // Loader phase
  dsc_state_t state_nxt;
  logic [2:0] wait_r;      // Settling counter
  logic [2:0] wait_nxt;
  dsc_cfg_t   cfg_r;       // Held configuration
  dsc_cfg_t   cfg_nxt;
  logic       valid_r;     // Held config is good to use
  logic       valid_nxt;
  dsc_cfg_t   dec_cfg;     // Live decode of synced banks

  // Bit order follows the pins: bit 0 is switch position 1
  dsc_decode u_decode (
    .rate_sw_i (rate_s2_r),
    .node_sw_i (node_s2_r),
    .cfg_o     (dec_cfg)
  );

  // Synchroniser next values
  always_comb
  begin
    rate_s1_nxt = RATE_SW_I;
    rate_s2_nxt = rate_s1_r;
    node_s1_nxt = NODE_SW_I;
    node_s2_nxt = node_s1_r;
  end

  // Synchroniser registers; reset to the factory settings
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      rate_s1_r <= `DSC_RATE_DEF;
      rate_s2_r <= `DSC_RATE_DEF;
      node_s1_r <= `DSC_NODE_DEF;
      node_s2_r <= `DSC_NODE_DEF;
    end
    else
    begin
      rate_s1_r <= rate_s1_nxt;
      rate_s2_r <= rate_s2_nxt;
      node_s1_r <= node_s1_nxt;
      node_s2_r <= node_s2_nxt;
    end
  end

  // Loader sequencing: wait out the synchroniser, sample once, hold
  always_comb
  begin
    state_nxt = state_r;
    wait_nxt  = wait_r;
    cfg_nxt   = cfg_r;
    valid_nxt = valid_r;
    case (state_r)
      DSC_ST_RESET:
      begin
        // Stages still hold reset values; let pins flow through first
        state_nxt = DSC_ST_SYNC;
        wait_nxt  = '0;
      end
      DSC_ST_SYNC:
      begin
        if (wait_r == WAIT_LAST)
        begin
          // Single capture; later switch changes need a reset
          cfg_nxt   = dec_cfg;
          valid_nxt = 1'b1;
          state_nxt = DSC_ST_HOLD;
        end
        else
        begin
          wait_nxt = wait_r + 3'h1;
        end
      end
      DSC_ST_HOLD:
      begin
        // Held until the next reset
        state_nxt = DSC_ST_HOLD;
      end
      default:
      begin
        state_nxt = DSC_ST_RESET;
      end
    endcase
  end

  // Loader registers
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      state_r <= DSC_ST_RESET;
      wait_r  <= '0;
      cfg_r   <= '0;
      valid_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      wait_r  <= wait_nxt;
      cfg_r   <= cfg_nxt;
      valid_r <= valid_nxt;
    end
  end

  // Outputs straight from the held registers
  always_comb
  begin
    CFG_VALID_O = valid_r;
    AUTO_SCAN_O = cfg_r.auto_scan;
    RATE_BAD_O  = cfg_r.rate_bad;
    RATE_KBPS_O = cfg_r.kbps;
    NODE_BAD_O  = cfg_r.node_bad;
    NODE_ID_O   = cfg_r.node_id;
  end

endmodule

// ===== tb/dsc_config_loader_asserts.sv
// Checker for the switch bank configuration decoder top.
// Assumes it is bound to the top and that switches stay still across a capture.
`timescale 1ns/1ps
module dsc_config_loader_asserts #(
  parameter int SYNC_WAIT = 4  // Matches the top, capture delay
)
(
  input wire logic       REF_CLK_I,
  input wire logic       RST_I,
  input wire logic [3:0] RATE_SW_I,
  input wire logic [7:0] NODE_SW_I,
  input wire logic       CFG_VALID_O,
  input wire logic       AUTO_SCAN_O,
  input wire logic       RATE_BAD_O,
  input wire logic [9:0] RATE_KBPS_O,
  input wire logic       NODE_BAD_O,
  input wire logic [6:0] NODE_ID_O
);
  // One clock domain, reset quiets every check
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  // Cycles since reset release, saturating; sampled value is the edge count minus one
  logic [3:0] rel_cnt;
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      rel_cnt <= 4'h0;
    end
    else if (rel_cnt != 4'hf)
    begin
      rel_cnt <= rel_cnt + 4'h1;
    end
  end
  // Valid must rise on exactly the edge the wait count implies, never earlier
  chk_valid_exact_edge: assert property (CFG_VALID_O == (int'(rel_cnt) > SYNC_WAIT))
    else $error("capture edge differs from the wait count");
  chk_hold_after_load: assert property (CFG_VALID_O |=> CFG_VALID_O && $stable({AUTO_SCAN_O,
    RATE_BAD_O, RATE_KBPS_O, NODE_BAD_O, NODE_ID_O})) else $error("output moved after capture");
  chk_valid_in_time: assert property ($fell(RST_I) |-> !CFG_VALID_O[*3] ##[1:8] CFG_VALID_O)
    else $error("capture not on time");
  chk_auto_no_rate: assert property (AUTO_SCAN_O |-> RATE_KBPS_O == 10'h000)
    else $error("auto scan with a fixed rate");
  chk_rate_in_table: assert property (CFG_VALID_O && !AUTO_SCAN_O && !RATE_BAD_O |->
    RATE_KBPS_O inside {10'h00a, 10'h014, 10'h032, 10'h064, 10'h07d, 10'h0fa, 10'h1f4,
    10'h320, 10'h3e8}) else $error("rate not in table");
  chk_zero_node_bad: assert property (NODE_BAD_O |-> NODE_ID_O == 7'h00)
    else $error("invalid node kept an identity");
  chk_node_from_bank: assert property ($rose(CFG_VALID_O) && !NODE_BAD_O |->
    NODE_ID_O == NODE_SW_I[6:0] && NODE_SW_I != 8'h00 && !NODE_SW_I[7])
    else $error("node identity not the bank value");
endmodule

// ===== tb/dsc_sw_bank.sv
// Model of the two switch banks in front of the decoder.
// Assumes the bench sets new positions while the decoder is in reset, except in the hold test after capture.
`timescale 1ns/1ps
module dsc_sw_bank (
  input  wire logic       clk_i,   // Bench clock
  input  wire logic       load_i,  // Move the switches
  input  wire logic [3:0] rate_i,  // New rate positions
  input  wire logic [7:0] node_i,  // New node positions
  output logic      [3:0] rate_o,  // Rate bank pins
  output logic      [7:0] node_o   // Node bank pins
);
  // As delivered: rate 0001, node 0010 0000
  initial rate_o = 4'h1;
  initial node_o = 8'h20;
  // Switches are levels, they stay where set
  always @(posedge clk_i)
    if (load_i)
    begin
      rate_o <= rate_i;
      node_o <= node_i;
    end
endmodule

// ===== tb/tb_dsc_config_loader.sv
// Bench for the switch bank configuration decoder.
// Assumes the switch model and checker files are compiled alongside.
`timescale 1ns/1ps
module tb_dsc_config_loader;
  logic clk = 0, rst = 1, ld = 0;
  logic [3:0] rs = 4'h0, rp;
  logic [7:0] ns = 8'h00, np;
  logic v, au, rb, nb;
  logic [9:0] kb;
  logic [6:0] id;
  int err_count = 0, num_checks = 0;
  logic [9:0] tbl [9] = '{10'h00a, 10'h014, 10'h032, 10'h064, 10'h07d, 10'h0fa, 10'h1f4,
    10'h320, 10'h3e8};
  initial forever #4 clk = ~clk;
  dsc_sw_bank sw (.clk_i(clk), .load_i(ld), .rate_i(rs), .node_i(ns), .rate_o(rp), .node_o(np));
  dsc_config_loader #(.SYNC_WAIT(4)) dut (.REF_CLK_I(clk), .RST_I(rst), .RATE_SW_I(rp),
    .NODE_SW_I(np), .CFG_VALID_O(v), .AUTO_SCAN_O(au), .RATE_BAD_O(rb), .RATE_KBPS_O(kb),
    .NODE_BAD_O(nb), .NODE_ID_O(id));
  // Wide enough for the full output word, so no field is silently dropped
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic finish_test;
    if (err_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Reset, release, wait a bounded time for capture
  task automatic apply(input logic [3:0] r, input logic [7:0] n);
    @(posedge clk); ld <= 1; rs <= r; ns <= n; rst <= 1;
    @(posedge clk); ld <= 0;
    repeat (2) @(posedge clk);
    rst <= 0;
    repeat (20) if (v !== 1'b1) @(posedge clk) #1;
    check(v, 1'b1);
  endtask
  task automatic t_rates;
    for (int i = 0; i < 16; i++)
    begin
      // Node kept low, as an installer would for the default mapping
      apply(i[3:0], 8'h01);
      check({au, rb, kb, nb, id}, {i == 9, i > 9, i < 9 ? tbl[i] : 10'h000, 8'h01});
    end
  endtask
  task automatic t_nodes;
    logic [7:0] nv [5] = '{8'h00, 8'h01, 8'h2a, 8'h7f, 8'h80};
    for (int i = 0; i < 5; i++)
    begin
      apply(4'h8, nv[i]);
      check({nb, id}, (nv[i] == 8'h00 || nv[i][7]) ? 8'h80 : nv[i]);
    end
  endtask
  task automatic t_hold;
    apply(4'h9, 8'h7e);
    @(posedge clk); ld <= 1; rs <= 4'h2; ns <= 8'h05;
    repeat (10) @(posedge clk);
    ld <= 0;
    check({au, kb, id}, {1'b1, 10'h000, 7'h7e});
  endtask
  // First release of reset with the switches as delivered
  task automatic t_factory;
    repeat (3) @(posedge clk);
    rst <= 0;
    repeat (20) if (v !== 1'b1) @(posedge clk) #1;
    check({v, au, rb, kb, nb, id}, {3'h4, 10'h014, 8'h20});
  endtask
  initial
  begin
    t_factory;
    t_rates;
    t_nodes;
    t_hold;
    finish_test;
  end
  initial
  begin
    #20us;
    err_count++;
    finish_test;
  end
endmodule
bind dsc_config_loader dsc_config_loader_asserts #(.SYNC_WAIT(SYNC_WAIT)) u_chk (.REF_CLK_I,
  .RST_I, .RATE_SW_I, .NODE_SW_I, .CFG_VALID_O, .AUTO_SCAN_O, .RATE_BAD_O, .RATE_KBPS_O,
  .NODE_BAD_O, .NODE_ID_O);
